// ===== rtl/opss_phase_step.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Eight trigger bits, one per output; a 0 to 1 change starts one coarse step on that output.
// [R2] A coarse step inserts the 5-bit amount of whole periods of that output's selected source.
// [R3] Software waits for the output's pending flag to clear before triggering it again.
// [R4] A new coarse step needs the trigger bit cleared and set again; a held 1 does nothing.
// [R5] Outputs two and three add a 4-bit fine offset in sixteenths of the source period.
// [R6] A new fine value takes effect only when the sync bit is toggled; until then the old one holds.
// [R7] Toggling the sync bit clears all accumulated coarse delay.
// [R8] A 0 to 1 change of the sync bit holds all PLL-fed output dividers in reset.
// [R9] A 1 to 0 change releases them together with coarse adjustment cleared.
// [R10] Outputs four to seven select PLL, output two, three, reference zero, one or crystal.
// [R11] Software does not program the reserved selector codes 001 and 110.
// [R12] Software does not route a too fast input reference to outputs four to seven.
// [R13] Selectors reset to PLL, output two, PLL and reference one for outputs four to seven.
// [R14] Reserved bits are written as zero and read back as zero here.
// [R15] The trigger bits reset to zero so no step starts until software sets one.
// [R16] Each output's pending flag is high from the trigger edge until all periods are inserted.
module opss_phase_step
  import opss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [OPSS_NUM_OUT-1:0] out_src_edge,
  output logic [OPSS_NUM_OUT-1:0] divider_hold,
  output logic [OPSS_NUM_OUT-1:0] period_swallow,
  output logic [OPSS_NUM_OUT-1:0] phase_step_pending,
  output logic [3:0] fine_active_out_two,
  output logic [3:0] fine_active_out_three,
  output logic [2:0] source_select_out_four,
  output logic [2:0] source_select_out_five,
  output logic [2:0] source_select_out_six,
  output logic [2:0] source_select_out_seven
);
  // Source edges of each output's selected clock arrive as one-cycle pulses from the dividers.
  logic [7:0] phase_step_trigger_reg, phase_step_trigger_next;
  logic [4:0] whole_period_step_count_reg [OPSS_NUM_OUT];
  logic [4:0] whole_period_step_count_next [OPSS_NUM_OUT];
  logic [3:0] sixteenth_step_count_reg [OPSS_NUM_FRAC];
  logic [3:0] sixteenth_step_count_next [OPSS_NUM_FRAC];
  logic [3:0] fine_active_reg [OPSS_NUM_FRAC];
  logic [3:0] fine_active_next [OPSS_NUM_FRAC];
  logic divider_sync_hold_reg, divider_sync_hold_next;
  logic [2:0] sel_reg [4];
  logic [2:0] sel_next [4];
  logic [4:0] remain_reg [OPSS_NUM_OUT];
  logic [4:0] remain_next [OPSS_NUM_OUT];
  logic [OPSS_NUM_OUT-1:0] pending_reg, pending_next;
  logic [OPSS_NUM_OUT-1:0] swallow_reg, swallow_next;
  logic [OPSS_NUM_OUT-1:0] hold_reg, hold_next;
  logic [OPSS_NUM_OUT-1:0] pll_fed;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] trig_rise;
  logic sync_rise, sync_fall, sync_wr;

  always_comb begin
    phase_step_trigger_next = phase_step_trigger_reg;
    divider_sync_hold_next = divider_sync_hold_reg;
    sync_wr = 1'b0;
    for (int i = 0; i < OPSS_NUM_OUT; i++) begin
      whole_period_step_count_next[i] = whole_period_step_count_reg[i];
    end
    for (int i = 0; i < OPSS_NUM_FRAC; i++) begin
      sixteenth_step_count_next[i] = sixteenth_step_count_reg[i];
    end
    for (int i = 0; i < 4; i++) begin
      sel_next[i] = sel_reg[i];
    end
    if (reg_wr) begin
      if (reg_addr == OPSS_ADDR_TRIG) begin
        phase_step_trigger_next = reg_wdata; // [R1]
      end
      for (int i = 0; i < OPSS_NUM_OUT; i++) begin
        if (reg_addr == OPSS_ADDR_COARSE0 + 8'(i)) begin
          whole_period_step_count_next[i] = reg_wdata[4:0]; // [R2]
        end
      end
      if (reg_addr == OPSS_ADDR_FINE2) begin
        sixteenth_step_count_next[0] = reg_wdata[3:0];
      end
      if (reg_addr == OPSS_ADDR_FINE3) begin
        sixteenth_step_count_next[1] = reg_wdata[3:0];
      end
      if (reg_addr == OPSS_ADDR_SYNC) begin
        divider_sync_hold_next = reg_wdata[OPSS_SYNC_BIT];
        sync_wr = 1'b1;
      end
      if (reg_addr == OPSS_ADDR_SEL45) begin
        sel_next[0] = reg_wdata[OPSS_SEL_LO +: 3]; // [R10]
        sel_next[1] = reg_wdata[OPSS_SEL_HI +: 3];
      end
      if (reg_addr == OPSS_ADDR_SEL67) begin
        sel_next[2] = reg_wdata[OPSS_SEL_LO +: 3];
        sel_next[3] = reg_wdata[OPSS_SEL_HI +: 3];
      end
    end
  end

  assign trig_rise = phase_step_trigger_next & ~phase_step_trigger_reg; // [R1] [R4]
  assign sync_rise = sync_wr & divider_sync_hold_next & ~divider_sync_hold_reg;
  assign sync_fall = sync_wr & ~divider_sync_hold_next & divider_sync_hold_reg;

  // Outputs zero to three always run from the PLL; four to seven follow their selector.
  always_comb begin
    pll_fed = '1;
    for (int i = 0; i < 4; i++) begin
      pll_fed[i + 4] = (sel_reg[i] == OPSS_SRC_PLL); // [R10]
    end
  end

  generate
    for (genvar g = 0; g < OPSS_NUM_OUT; g++) begin : g_out
      always_comb begin
        remain_next[g] = remain_reg[g];
        pending_next[g] = pending_reg[g];
        swallow_next[g] = 1'b0;
        hold_next[g] = hold_reg[g];
        if (sync_rise && pll_fed[g]) begin
          hold_next[g] = 1'b1; // [R8]
        end
        if (sync_fall) begin
          hold_next[g] = 1'b0; // [R9]
        end
        if (sync_rise || sync_fall) begin
          remain_next[g] = '0; // [R7] [R9]
          pending_next[g] = 1'b0;
        end else if (trig_rise[g]) begin
          remain_next[g] = whole_period_step_count_next[g]; // [R2]
          pending_next[g] = (whole_period_step_count_next[g] != '0); // [R16]
        end else if (pending_reg[g] && out_src_edge[g] && !hold_reg[g]) begin
          // Swallowing one source edge delays the output by one whole period.
          swallow_next[g] = 1'b1; // [R2]
          remain_next[g] = remain_reg[g] - 5'd1;
          pending_next[g] = (remain_reg[g] != 5'd1); // [R16]
        end
      end
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < OPSS_NUM_FRAC; i++) begin
      fine_active_next[i] = fine_active_reg[i];
      if (sync_rise || sync_fall) begin
        fine_active_next[i] = sixteenth_step_count_reg[i]; // [R5] [R6]
      end
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      rdata_next = 8'h00; // [R14]
      if (reg_addr == OPSS_ADDR_TRIG) begin
        rdata_next = phase_step_trigger_reg;
      end
      for (int i = 0; i < OPSS_NUM_OUT; i++) begin
        if (reg_addr == OPSS_ADDR_COARSE0 + 8'(i)) begin
          rdata_next = {3'h0, whole_period_step_count_reg[i]};
        end
      end
      if (reg_addr == OPSS_ADDR_FINE2) begin
        rdata_next = {4'h0, sixteenth_step_count_reg[0]};
      end
      if (reg_addr == OPSS_ADDR_FINE3) begin
        rdata_next = {4'h0, sixteenth_step_count_reg[1]};
      end
      if (reg_addr == OPSS_ADDR_SYNC) begin
        rdata_next[OPSS_SYNC_BIT] = divider_sync_hold_reg;
      end
      if (reg_addr == OPSS_ADDR_SEL45) begin
        rdata_next = {1'b0, sel_reg[1], 1'b0, sel_reg[0]};
      end
      if (reg_addr == OPSS_ADDR_SEL67) begin
        rdata_next = {1'b0, sel_reg[3], 1'b0, sel_reg[2]};
      end
      if (reg_addr == OPSS_ADDR_FIXED) begin
        rdata_next = OPSS_FIXED_VALUE;
      end
      if (reg_addr == OPSS_ADDR_BUSY) begin
        rdata_next = pending_reg; // [R16]
      end
    end
  end

  // The trigger is kept as written, so a later rise needs the bit cleared first.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_step_trigger_reg <= OPSS_TRIG_RST; // [R15]
    end else begin
      phase_step_trigger_reg <= phase_step_trigger_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divider_sync_hold_reg <= 1'b0;
    end else begin
      divider_sync_hold_reg <= divider_sync_hold_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_reg[0] <= OPSS_SEL4_RST; // [R13]
      sel_reg[1] <= OPSS_SEL5_RST;
      sel_reg[2] <= OPSS_SEL6_RST;
      sel_reg[3] <= OPSS_SEL7_RST;
    end else begin
      sel_reg <= sel_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < OPSS_NUM_OUT; i++) begin
        whole_period_step_count_reg[i] <= OPSS_COARSE_RST;
      end
    end else begin
      whole_period_step_count_reg <= whole_period_step_count_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < OPSS_NUM_FRAC; i++) begin
        sixteenth_step_count_reg[i] <= OPSS_FINE_RST;
      end
    end else begin
      sixteenth_step_count_reg <= sixteenth_step_count_next;
    end
  end

  // The active fine offset is a separate copy so a new value waits for the sync toggle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < OPSS_NUM_FRAC; i++) begin
        fine_active_reg[i] <= OPSS_FINE_RST;
      end
    end else begin
      fine_active_reg <= fine_active_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < OPSS_NUM_OUT; i++) begin
        remain_reg[i] <= '0;
      end
    end else begin
      remain_reg <= remain_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      swallow_reg <= '0;
    end else begin
      swallow_reg <= swallow_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  // Read data is registered so the bus sees it one cycle after the read strobe.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign divider_hold = hold_reg;
  assign period_swallow = swallow_reg;
  assign phase_step_pending = pending_reg;
  assign fine_active_out_two = fine_active_reg[0];
  assign fine_active_out_three = fine_active_reg[1];
  assign source_select_out_four = sel_reg[0];
  assign source_select_out_five = sel_reg[1];
  assign source_select_out_six = sel_reg[2];
  assign source_select_out_seven = sel_reg[3];
endmodule : opss_phase_step
`default_nettype wire

// ===== rtl/opss_pkg.sv
package opss_pkg;
  localparam int OPSS_NUM_OUT = 8;
  localparam int OPSS_NUM_FRAC = 2;
  localparam logic [7:0] OPSS_ADDR_TRIG = 8'h9D;
  localparam logic [7:0] OPSS_ADDR_COARSE0 = 8'h9E;
  localparam logic [7:0] OPSS_ADDR_FINE2 = 8'hA6;
  localparam logic [7:0] OPSS_ADDR_FINE3 = 8'hA7;
  localparam logic [7:0] OPSS_ADDR_SYNC = 8'hA8;
  localparam logic [7:0] OPSS_ADDR_SEL45 = 8'hA9;
  localparam logic [7:0] OPSS_ADDR_SEL67 = 8'hAA;
  localparam logic [7:0] OPSS_ADDR_FIXED = 8'hAB;
  localparam logic [7:0] OPSS_ADDR_BUSY = 8'hB0;
  localparam int OPSS_SYNC_BIT = 4;
  localparam int OPSS_SEL_LO = 0;
  localparam int OPSS_SEL_HI = 4;
  localparam logic [7:0] OPSS_FIXED_VALUE = 8'h00;
  localparam logic [2:0] OPSS_SRC_PLL = 3'h0;
  localparam logic [2:0] OPSS_SRC_OUT2 = 3'h2;
  localparam logic [2:0] OPSS_SRC_OUT3 = 3'h3;
  localparam logic [2:0] OPSS_SRC_REF0 = 3'h4;
  localparam logic [2:0] OPSS_SRC_REF1 = 3'h5;
  localparam logic [2:0] OPSS_SRC_XTAL = 3'h7;
  localparam logic [2:0] OPSS_SEL4_RST = 3'h0;
  localparam logic [2:0] OPSS_SEL5_RST = 3'h2;
  localparam logic [2:0] OPSS_SEL6_RST = 3'h0;
  localparam logic [2:0] OPSS_SEL7_RST = 3'h5;
  localparam logic [7:0] OPSS_TRIG_RST = 8'h00;
  localparam logic [4:0] OPSS_COARSE_RST = 5'h00;
  localparam logic [3:0] OPSS_FINE_RST = 4'h0;
  localparam logic [1:0] OPSS_SRC_LINES = 2'h3;
endpackage : opss_pkg

// ===== test/opss_phase_step_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module opss_phase_step_asserts
  import opss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] out_src_edge,
  input wire logic [7:0] divider_hold,
  input wire logic [7:0] period_swallow,
  input wire logic [7:0] phase_step_pending,
  input wire logic [3:0] fine_active_out_two,
  input wire logic [3:0] fine_active_out_three,
  input wire logic [2:0] source_select_out_four,
  input wire logic [2:0] source_select_out_five,
  input wire logic [2:0] source_select_out_six,
  input wire logic [2:0] source_select_out_seven
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  swallow_edge_a:
  assert property ((period_swallow & ~$past(out_src_edge)) == 8'h00) else $error("swallow no edge");
  swallow_busy_a:
  assert property ((period_swallow & ~$past(phase_step_pending)) == 8'h00) else $error("idle swallow");
  sync_hold_a:
  assert property (reg_wr && reg_addr == OPSS_ADDR_SYNC && reg_wdata[OPSS_SYNC_BIT] |=>
    divider_hold[3:0] == 4'hF && divider_hold[4] == (source_select_out_four == 3'h0))
    else $error("dividers not held");
  sync_release_a:
  assert property (reg_wr && reg_addr == OPSS_ADDR_SYNC && !reg_wdata[OPSS_SYNC_BIT] |=>
    divider_hold == 8'h00) else $error("dividers not released");
  sync_clear_a:
  assert property ($changed(divider_hold[0]) |-> phase_step_pending == 8'h00)
    else $error("coarse steps survive sync");
  fine_keep_a:
  assert property (!$changed(divider_hold[0]) |-> $stable(fine_active_out_two) &&
    $stable(fine_active_out_three)) else $error("fine offset changed without sync");
  sel_write_a:
  assert property (reg_wr && reg_addr == OPSS_ADDR_SEL45 |=> source_select_out_four ==
    $past(reg_wdata[2:0]) && source_select_out_five == $past(reg_wdata[6:4]))
    else $error("selector not loaded");
  rsvd_read_a:
  assert property (reg_rd && reg_addr == OPSS_ADDR_SYNC |=> (reg_rdata & 8'hEF) == 8'h00)
    else $error("reserved bits nonzero");
endmodule : opss_phase_step_asserts
bind opss_phase_step opss_phase_step_asserts opss_phase_step_asserts_inst (.sys_clk(sys_clk),
  .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .out_src_edge(out_src_edge), .divider_hold(divider_hold),
  .period_swallow(period_swallow), .phase_step_pending(phase_step_pending),
  .fine_active_out_two(fine_active_out_two), .fine_active_out_three(fine_active_out_three),
  .source_select_out_four(source_select_out_four), .source_select_out_five(source_select_out_five),
  .source_select_out_six(source_select_out_six), .source_select_out_seven(source_select_out_seven));
`default_nettype wire

// ===== test/test_opss_phase_step.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_opss_phase_step
  import opss_pkg::*;
;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, out_src_edge = 0;
  logic [7:0] reg_rdata, hold, swallow, pend;
  logic [3:0] fine2, fine3;
  logic [2:0] sel4, sel5, sel6, sel7;
  logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  int err_count = 0, n_checks = 0;
  int sw [8];
  always #5 sys_clk = ~sys_clk;
  opss_phase_step opss_phase_step_inst (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .out_src_edge(out_src_edge), .divider_hold(hold), .period_swallow(swallow),
    .phase_step_pending(pend), .fine_active_out_two(fine2), .fine_active_out_three(fine3),
    .source_select_out_four(sel4), .source_select_out_five(sel5),
    .source_select_out_six(sel6), .source_select_out_seven(sel7));
  // Swallows are counted per output, since a missing or extra pulse is the costly fault.
  always @(posedge sys_clk) for (int i = 0; i < 8; i++) if (swallow[i] === 1'b1) sw[i]++;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    reg_wr = 0;
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge sys_clk);
    reg_rd = 0;
    @(negedge sys_clk);
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic pulse(input logic [7:0] m, input int n);
    repeat (n) begin
      @(negedge sys_clk);
      out_src_edge = m;
      @(negedge sys_clk);
      out_src_edge = 0;
    end
    @(negedge sys_clk);
  endtask : pulse
  task automatic step(input int m, input logic [4:0] amt);
    logic [7:0] b;
    b = 8'h01 << m;
    sw[m] = 0;
    wr(OPSS_ADDR_COARSE0 + 8'(m), {3'h0, amt});
    rd(OPSS_ADDR_COARSE0 + 8'(m), {3'h0, amt});
    wr(OPSS_ADDR_TRIG, b);
    `CHK(pend[m], amt != 0)
    rd(OPSS_ADDR_BUSY, (amt != 0) ? b : 8'h00);
    pulse(b, int'(amt) + 1);
    `CHK(sw[m], int'(amt))
    `CHK(pend[m], 1'b0)
    wr(OPSS_ADDR_TRIG, 8'h00);
  endtask : step
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 0;
    `CHK({sel4, sel5, sel6, sel7}, 12'h085)
    rd(OPSS_ADDR_TRIG, 8'h00);
    rd(OPSS_ADDR_SEL45, 8'h20);
    rd(OPSS_ADDR_SEL67, 8'h50);
    rd(OPSS_ADDR_FIXED, OPSS_FIXED_VALUE);
    $display("test reset_values done");
    step(0, 5'h03);
    step(7, 5'h1F);
    step(2, 5'h00);
    wr(OPSS_ADDR_COARSE0, 8'h02);
    wr(OPSS_ADDR_TRIG, 8'h01);
    wr(OPSS_ADDR_TRIG, 8'h01);
    sw[0] = 0;
    pulse(8'h01, 4);
    `CHK(sw[0], 2)
    $display("test coarse_step done");
    wr(OPSS_ADDR_FINE2, 8'h05);
    wr(OPSS_ADDR_FINE3, 8'h09);
    `CHK({fine2, fine3}, 8'h00)
    wr(OPSS_ADDR_TRIG, 8'h00);
    wr(OPSS_ADDR_TRIG, 8'h01);
    wr(OPSS_ADDR_SYNC, 8'h10);
    `CHK(hold, 8'h5F)
    `CHK(pend, 8'h00)
    `CHK({fine2, fine3}, 8'h59)
    sw[0] = 0;
    pulse(8'h01, 2);
    rd(OPSS_ADDR_SYNC, 8'h10);
    wr(OPSS_ADDR_SYNC, 8'h00);
    `CHK(hold, 8'h00)
    pulse(8'h01, 2);
    `CHK(sw[0], 0)
    wr(OPSS_ADDR_TRIG, 8'h00);
    $display("test sync done");
    for (int i = 0; i < 6; i++) begin
      wr(OPSS_ADDR_SEL45, {1'b0, codes[i], 1'b0, codes[5-i]});
      wr(OPSS_ADDR_SEL67, {1'b0, codes[5-i], 1'b0, codes[i]});
      `CHK({sel4, sel5, sel6, sel7}, {codes[5-i], codes[i], codes[i], codes[5-i]})
      rd(OPSS_ADDR_SEL45, {1'b0, codes[i], 1'b0, codes[5-i]});
    end
    $display("test source_select done");
    print_verdict;
  end
  initial begin
    #100000;
    err_count++;
    print_verdict;
  end
endmodule : test_opss_phase_step
`default_nettype wire
